// ---- include/flash_guard_consts.vh ----
`ifndef FLASH_GUARD_CONSTS_VH
`define FLASH_GUARD_CONSTS_VH

// Clock rate of the controller.
`define CLOCK_MHZ 40

// Bus cycle timing, in nanoseconds and in clock cycles.
`define WR_PULSE_NS 70
`define WR_PULSE_CYC (((`WR_PULSE_NS * `CLOCK_MHZ) + 999) / 1000)
`define RD_ACCESS_NS 70
`define RD_ACCESS_CYC (((`RD_ACCESS_NS * `CLOCK_MHZ) + 999) / 1000)
`define SYNC_CYC 2
`define RECOVER_NS 25
`define RECOVER_CYC (((`RECOVER_NS * `CLOCK_MHZ) + 999) / 1000)

// Flash command codes.
`define CMD_LOCK_SETUP 16'h0060
`define CMD_LOCK 16'h0001
`define CMD_UNLOCK 16'h00D0
`define CMD_LOCKDOWN 16'h002F
`define CMD_READ_ID 16'h0090
`define CMD_READ_ARRAY 16'h00FF
`define CMD_OTP_SETUP 16'h00C0
`define CMD_SUSPEND 16'h00B0
`define CMD_RESUME 16'h00D0
`define OTP_LOCK_VALUE 16'hFFFD

// Flash address layout.
`define FLASH_AW 22
`define LOCK_STATUS_OFS 22'h00_0002
`define OTP_LOCK_WORD_ADDR 22'h00_0080

// Flash status bit positions.
`define SR_READY 7
`define SR_ERASE_SUSP 6
`define SR_ERASE_ERR 5
`define SR_PROG_ERR 4
`define SR_SUPPLY_LOW 3
`define SR_LOCK_ERR 1

// Controller register offsets.
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_STATUS 8'h0C
`define REG_RDATA 8'h10
`define REG_WP 8'h14

// Operation codes written to the control register.
`define OP_LOCK 4'h0
`define OP_UNLOCK 4'h1
`define OP_LOCKDOWN 4'h2
`define OP_READ_LOCK 4'h3
`define OP_OTP_PROG 4'h4
`define OP_OTP_LOCK 4'h5
`define OP_READ_ID 4'h6
`define OP_SUSPEND 4'h7
`define OP_RESUME 4'h8
`define OP_READ_STATUS 4'h9
`define OP_READ_ARRAY 4'hA

// Reset values.
`define WP_RESET 1'b0
`define ADDR_RESET 22'h00_0000
`define DATA_RESET 16'h0000

`endif

// ---- logic/flash_cycle.v ----
`timescale 1ns/1ps
`include "flash_guard_consts.vh"

module flash_cycle (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Cycle request
    input wire start,
    input wire write_en,
    input wire [21:0] addr,
    input wire [15:0] wdata,
    output wire done,
    output reg [15:0] rdata_q,
    // Flash pins
    output reg [21:0] flash_addr_q,
    output reg [15:0] flash_dq_out_q,
    output reg flash_dq_oe_q,
    input wire [15:0] flash_dq_in,
    output reg flash_ce_n_q,
    output reg flash_we_n_q,
    output reg flash_oe_n_q
);
    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_SETUP = 4'b0010;
    localparam [3:0] S_PULSE = 4'b0100;
    localparam [3:0] S_HOLD = 4'b1000;
    localparam integer WR_CYC = `WR_PULSE_CYC;
    localparam integer RD_CYC = `RD_ACCESS_CYC + `SYNC_CYC;
    localparam integer REC_CYC = `RECOVER_CYC;

    reg [3:0] state_q;
    reg [3:0] cnt_q;
    reg wr_q;
    reg done_q;
    reg [15:0] sync1_q;
    reg [15:0] sync2_q;

    assign done = done_q;

    always @(posedge clock) begin
        sync1_q <= flash_dq_in;
        sync2_q <= sync1_q;
    end

    always @(posedge clock) begin
        if (reset) begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
            wr_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= `DATA_RESET;
            flash_addr_q <= `ADDR_RESET;
            flash_dq_out_q <= `DATA_RESET;
            flash_dq_oe_q <= 1'b0;
            flash_ce_n_q <= 1'b1;
            flash_we_n_q <= 1'b1;
            flash_oe_n_q <= 1'b1;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (start) begin
                        wr_q <= write_en;
                        flash_addr_q <= addr;
                        flash_dq_out_q <= wdata;
                        flash_dq_oe_q <= write_en;
                        flash_ce_n_q <= 1'b0;
                        state_q <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    flash_we_n_q <= ~wr_q;
                    flash_oe_n_q <= wr_q;
                    cnt_q <= wr_q ? WR_CYC[3:0] : RD_CYC[3:0];
                    state_q <= S_PULSE;
                end
                S_PULSE: begin
                    if (cnt_q == 4'h1) begin
                        // Data is taken from the second synchroniser stage only.
                        if (!wr_q) begin
                            rdata_q <= sync2_q;
                        end
                        flash_we_n_q <= 1'b1;
                        flash_oe_n_q <= 1'b1;
                        cnt_q <= REC_CYC[3:0];
                        state_q <= S_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                S_HOLD: begin
                    // Address and data stay put past the rising strobe so the latch sees them.
                    if (cnt_q <= 4'h1) begin
                        flash_ce_n_q <= 1'b1;
                        flash_dq_oe_q <= 1'b0;
                        done_q <= 1'b1;
                        state_q <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- logic/flash_guard_host.v ----
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "flash_guard_consts.vh"

// Operation
// - Lock: 0x60 then 0x01 to block
// - Unlock: 0x60 then 0xD0 to block
// - Lockdown: 0x60 then 0x2F to block
// - Identifier read at base plus two
// - Suspend erase, poll, lock, then resume
// - Identifier mode reads protection, 0xFF exits
// - Protection program: 0xC0 then data write
// - Segment locked by writing 0xFFFD

module flash_guard_host (
    // Clock and reset
    input wire clock,
    input wire reset,
    // AXI4-Lite write channels
    input wire awvalid,
    output wire awready,
    input wire [7:0] awaddr,
    input wire [2:0] awprot,
    input wire wvalid,
    output wire wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    // AXI4-Lite read channels
    input wire arvalid,
    output wire arready,
    input wire [7:0] araddr,
    input wire [2:0] arprot,
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    // Flash pins
    output wire [21:0] flash_addr,
    output wire [15:0] flash_dq_out,
    output wire flash_dq_oe,
    input wire [15:0] flash_dq_in,
    output wire flash_ce_n,
    output wire flash_we_n,
    output wire flash_oe_n,
    output reg write_protect_n_q
);
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_RUN = 3'b010;
    localparam [2:0] S_WAIT = 3'b100;

    reg [2:0] state_q;
    reg [3:0] op_q;
    reg [1:0] step_q;
    reg [21:0] addr_q;
    reg [15:0] wdata_q;
    reg [15:0] result_q;
    reg lock_error_flag_q;
    reg supply_low_flag_q;
    reg program_error_flag_q;
    reg erase_error_flag_q;
    reg block_lock_bit_q;
    reg block_lockdown_bit_q;
    reg aw_held_q;
    reg [7:0] aw_addr_q;
    reg w_held_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    wire cyc_done;
    wire [15:0] cyc_rdata;
    wire busy = (state_q != S_IDLE);

    // Current step of the sequence table.
    reg st_wr;
    reg [15:0] st_data;
    reg st_plus2;
    reg st_lockword;
    reg st_status;
    reg st_lockread;
    reg st_poll;
    reg st_last;
    wire [21:0] st_addr = st_lockword ? `OTP_LOCK_WORD_ADDR : (st_plus2 ? addr_q + `LOCK_STATUS_OFS : addr_q);

    always @* begin
        st_wr = 1'b1;
        st_data = `CMD_LOCK_SETUP;
        st_plus2 = 1'b0;
        st_lockword = 1'b0;
        st_status = 1'b0;
        st_lockread = 1'b0;
        st_poll = 1'b0;
        st_last = 1'b0;
        case (op_q)
            `OP_LOCK, `OP_UNLOCK, `OP_LOCKDOWN: begin
                // Two-cycle sequence to the block, then the status that it leaves behind.
                if (step_q == 2'd1) begin
                    st_data = (op_q == `OP_LOCK) ? `CMD_LOCK :
                              (op_q == `OP_UNLOCK) ? `CMD_UNLOCK : `CMD_LOCKDOWN;
                end else if (step_q == 2'd2) begin
                    st_wr = 1'b0;
                    st_status = 1'b1;
                    st_last = 1'b1;
                end
            end
            `OP_READ_LOCK, `OP_READ_ID: begin
                if (step_q == 2'd0) begin
                    st_data = `CMD_READ_ID;
                end else if (step_q == 2'd1) begin
                    st_wr = 1'b0;
                    st_plus2 = (op_q == `OP_READ_LOCK);
                    st_lockread = (op_q == `OP_READ_LOCK);
                end else begin
                    st_data = `CMD_READ_ARRAY;
                    st_last = 1'b1;
                end
            end
            `OP_OTP_PROG, `OP_OTP_LOCK: begin
                st_lockword = (op_q == `OP_OTP_LOCK);
                if (step_q == 2'd0) begin
                    st_data = `CMD_OTP_SETUP;
                end else if (step_q == 2'd1) begin
                    st_data = (op_q == `OP_OTP_LOCK) ? `OTP_LOCK_VALUE : wdata_q;
                end else begin
                    st_wr = 1'b0;
                    st_status = 1'b1;
                    st_last = 1'b1;
                end
            end
            `OP_SUSPEND: begin
                if (step_q == 2'd0) begin
                    st_data = `CMD_SUSPEND;
                end else begin
                    st_wr = 1'b0;
                    st_status = 1'b1;
                    st_poll = 1'b1;
                    st_last = 1'b1;
                end
            end
            `OP_RESUME: begin
                st_data = `CMD_RESUME;
                st_last = 1'b1;
            end
            `OP_READ_STATUS: begin
                st_wr = 1'b0;
                st_status = 1'b1;
                st_last = 1'b1;
            end
            `OP_READ_ARRAY: begin
                if (step_q == 2'd0) begin
                    st_data = `CMD_READ_ARRAY;
                end else begin
                    st_wr = 1'b0;
                    st_last = 1'b1;
                end
            end
            default: begin
                st_last = 1'b1;
            end
        endcase
    end

    flash_cycle cycle (
        .clock(clock),
        .reset(reset),
        .start(state_q == S_RUN),
        .write_en(st_wr),
        .addr(st_addr),
        .wdata(st_data),
        .done(cyc_done),
        .rdata_q(cyc_rdata),
        .flash_addr_q(flash_addr),
        .flash_dq_out_q(flash_dq_out),
        .flash_dq_oe_q(flash_dq_oe),
        .flash_dq_in(flash_dq_in),
        .flash_ce_n_q(flash_ce_n),
        .flash_we_n_q(flash_we_n),
        .flash_oe_n_q(flash_oe_n)
    );

    // A write is acted on once both address and data are held, so they may arrive in either order.
    assign awready = !aw_held_q && !bvalid;
    assign wready = !w_held_q && !bvalid;
    assign arready = !rvalid;
    wire do_write = aw_held_q && w_held_q;
    wire [31:0] strb_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wire [31:0] wmerge_addr = ({10'h000, addr_q} & ~strb_mask) | (w_data_q & strb_mask);
    wire [31:0] wmerge_data = ({16'h0000, wdata_q} & ~strb_mask) | (w_data_q & strb_mask);
    wire known_wr = (aw_addr_q == `REG_CTRL) || (aw_addr_q == `REG_ADDR) || (aw_addr_q == `REG_WDATA) ||
                    (aw_addr_q == `REG_WP) || (aw_addr_q == `REG_STATUS) || (aw_addr_q == `REG_RDATA);
    wire start_op = do_write && (aw_addr_q == `REG_CTRL) && w_strb_q[0] && !busy && (w_data_q[3:0] <= `OP_READ_ARRAY);

    always @(posedge clock) begin
        if (reset) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'b00;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'b00;
            addr_q <= `ADDR_RESET;
            wdata_q <= `DATA_RESET;
            write_protect_n_q <= `WP_RESET;
        end else begin
            if (awvalid && awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= {awaddr[7:2], 2'b00};
            end
            if (wvalid && wready) begin
                w_held_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= known_wr ? 2'b00 : 2'b10;
                // Operands are frozen while an operation runs so the sequence stays coherent.
                if (!busy && aw_addr_q == `REG_ADDR) begin
                    addr_q <= wmerge_addr[21:0];
                end
                if (!busy && aw_addr_q == `REG_WDATA) begin
                    wdata_q <= wmerge_data[15:0];
                end
                if (aw_addr_q == `REG_WP && w_strb_q[0]) begin
                    write_protect_n_q <= w_data_q[0];
                end
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rresp <= 2'b00;
                case ({araddr[7:2], 2'b00})
                    `REG_CTRL: rdata <= {28'h000_0000, op_q};
                    `REG_ADDR: rdata <= {10'h000, addr_q};
                    `REG_WDATA: rdata <= {16'h0000, wdata_q};
                    `REG_STATUS: rdata <= {21'h00_0000, write_protect_n_q, block_lockdown_bit_q, block_lock_bit_q,
                                           2'b00, erase_error_flag_q, program_error_flag_q, supply_low_flag_q,
                                           1'b0, lock_error_flag_q, busy};
                    `REG_RDATA: rdata <= {16'h0000, result_q};
                    `REG_WP: rdata <= {31'h0000_0000, write_protect_n_q};
                    default: begin
                        rdata <= 32'h0000_0000;
                        rresp <= 2'b10;
                    end
                endcase
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    always @(posedge clock) begin
        if (reset) begin
            state_q <= S_IDLE;
            op_q <= `OP_LOCK;
            step_q <= 2'd0;
            result_q <= `DATA_RESET;
            lock_error_flag_q <= 1'b0;
            supply_low_flag_q <= 1'b0;
            program_error_flag_q <= 1'b0;
            erase_error_flag_q <= 1'b0;
            block_lock_bit_q <= 1'b1;
            block_lockdown_bit_q <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (start_op) begin
                        op_q <= w_data_q[3:0];
                        step_q <= 2'd0;
                        state_q <= S_RUN;
                    end
                end
                S_RUN: begin
                    state_q <= S_WAIT;
                end
                S_WAIT: begin
                    if (cyc_done) begin
                        if (!st_wr) begin
                            result_q <= cyc_rdata;
                        end
                        if (st_status) begin
                            // Flags mirror the device's own status word as last read.
                            lock_error_flag_q <= cyc_rdata[`SR_LOCK_ERR];
                            supply_low_flag_q <= cyc_rdata[`SR_SUPPLY_LOW];
                            program_error_flag_q <= cyc_rdata[`SR_PROG_ERR];
                            erase_error_flag_q <= cyc_rdata[`SR_ERASE_ERR];
                        end
                        if (st_lockread) begin
                            block_lock_bit_q <= cyc_rdata[0];
                            block_lockdown_bit_q <= cyc_rdata[1];
                        end
                        if (st_poll && !(cyc_rdata[`SR_READY] && cyc_rdata[`SR_ERASE_SUSP])) begin
                            state_q <= S_RUN;
                        end else if (st_last) begin
                            state_q <= S_IDLE;
                        end else begin
                            step_q <= step_q + 2'd1;
                            state_q <= S_RUN;
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- testbench/flash_guard_host_assertions.sv ----
`timescale 1ns/1ps
module flash_guard_host_assertions (
    // Clock and reset
    input wire clock,
    input wire reset,
    // Register bus handshakes
    input wire awvalid,
    input wire awready,
    input wire wvalid,
    input wire wready,
    input wire bvalid,
    input wire arvalid,
    input wire arready,
    input wire rvalid,
    // Flash pins
    input wire [15:0] flash_dq_out,
    input wire flash_dq_oe,
    input wire flash_ce_n,
    input wire flash_we_n,
    input wire flash_oe_n,
    input wire write_protect_n_q
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    a_reset_idle: assert property ($fell(reset) |-> flash_ce_n && flash_we_n && flash_oe_n
        && !flash_dq_oe && !bvalid && !rvalid && !write_protect_n_q) else $error("not idle after reset");
    a_we_pulse: assert property ($fell(flash_we_n) |-> !flash_we_n [*3] ##1 flash_we_n)
        else $error("write strobe width wrong");
    a_we_framed: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
        else $error("write strobe without select");
    a_read_pulse: assert property ($fell(flash_oe_n) |-> (!flash_oe_n && !flash_ce_n && !flash_dq_oe) [*5]
        ##1 flash_oe_n) else $error("read strobe width wrong");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");
    a_read_answer: assert property (arvalid && arready |=> rvalid) else $error("read answer late");
    a_data_steady: assert property (!flash_we_n |-> $stable(flash_dq_out)) else $error("data moved");
    a_lock_confirm: assert property ($fell(flash_we_n) && flash_dq_out == 16'h0060 |-> ##[2:40]
        ($fell(flash_we_n) && flash_dq_out inside {16'h0001, 16'h00D0, 16'h002F})) else $error("bad confirm");
    a_id_exit: assert property ($fell(flash_we_n) && flash_dq_out == 16'h0090 |-> ##[2:40]
        $fell(flash_oe_n) ##[2:40] ($fell(flash_we_n) && flash_dq_out == 16'h00FF)) else $error("no id exit");
    a_suspend_poll: assert property ($fell(flash_we_n) && flash_dq_out == 16'h00B0 |-> ##[2:40]
        $fell(flash_oe_n)) else $error("suspend not polled");
    a_otp_pair: assert property ($fell(flash_we_n) && flash_dq_out == 16'h00C0 |-> ##[2:40]
        $fell(flash_we_n) ##[2:40] $fell(flash_oe_n)) else $error("otp incomplete");
endmodule

// ---- testbench/flash_device_model.sv ----
`timescale 1ns/1ps
module flash_device_model (
    // Reset, supply and protect level
    input wire reset,
    input wire vpp_low,
    input wire write_protect_n_q,
    // Flash pins
    input wire [21:0] flash_addr,
    input wire [15:0] flash_dq_out,
    input wire flash_dq_oe,
    output wire [15:0] flash_dq_in,
    input wire flash_ce_n,
    input wire flash_we_n,
    input wire flash_oe_n
);
    reg lock_bit [0:127];
    reg down_bit [0:127];
    reg [15:0] otp [0:8];
    reg [7:0] sr;
    reg [1:0] mode;
    reg [15:0] pend;
    reg [15:0] val;
    reg [15:0] last;
    integer i;
    wire [6:0] blk = flash_addr[21:15];
    wire [21:0] ofs = flash_addr - 22'h00_0080;
    wire [15:0] d = flash_dq_out;

    task automatic clear_all;
        for (i = 0; i < 128; i = i + 1) begin
            lock_bit[i] = 1'b1;
            down_bit[i] = 1'b0;
        end
        sr = 8'h80;
        mode = 2'h0;
        pend = 16'h0000;
    endtask

    initial begin
        last = 16'h0000;
        val = 16'h0000;
        // Factory words hold an arbitrary pattern; the user half starts blank.
        for (i = 0; i < 9; i = i + 1) begin
            otp[i] = (i < 5) ? 16'h5AC3 : 16'hFFFF;
        end
        otp[0] = 16'hFFFE;
        clear_all();
    end

    always @(posedge reset) clear_all();

    always @(posedge flash_we_n) begin
        if (!flash_ce_n && flash_dq_oe && !reset) begin
            if (pend == 16'h0060) begin
                if (d == 16'h0001) lock_bit[blk] = 1'b1;
                else if (d == 16'h002F) begin
                    lock_bit[blk] = 1'b1;
                    down_bit[blk] = 1'b1;
                end else if (d == 16'h00D0) begin
                    if (!down_bit[blk] || write_protect_n_q) lock_bit[blk] = 1'b0;
                end else sr[5:4] = 2'b11;
                mode = 2'h1;
                pend = 16'h0000;
            end else if (pend == 16'h00C0) begin
                if (vpp_low) sr[3] = 1'b1;
                else if (ofs > 22'h00_0008 || (ofs != 22'h00_0000 && (ofs < 22'h00_0005 || !otp[0][1])))
                    sr = sr | 8'h12;
                else otp[ofs] = otp[ofs] & d;
                mode = 2'h1;
                pend = 16'h0000;
            end else begin
                pend = (d == 16'h0060 || d == 16'h00C0) ? d : 16'h0000;
                if (d == 16'h0090) mode = 2'h2;
                if (d == 16'h00FF) mode = 2'h0;
                if (d == 16'h00B0) begin
                    sr[7:6] = 2'b11;
                    mode = 2'h1;
                end
                if (d == 16'h00D0) sr[6] = 1'b0;
            end
        end
    end

    always @(negedge write_protect_n_q) begin
        for (i = 0; i < 128; i = i + 1) begin
            if (down_bit[i]) lock_bit[i] = 1'b1;
        end
    end

    always @(negedge flash_oe_n) begin
        if (mode == 2'h1) val = {8'h00, sr};
        else if (mode == 2'h2 && flash_addr[14:0] == 15'h0002) val = {14'h0000, down_bit[blk], lock_bit[blk]};
        else if (mode == 2'h2 && ofs < 22'h00_0009) val = otp[ofs];
        else val = flash_addr[15:0];
    end

    always @(posedge flash_oe_n) last = val;
    // A released bus shows the inverse of the last word so stale data cannot pass.
    assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? val : ~last;
endmodule

// ---- testbench/tb_flash_guard_host.sv ----
`timescale 1ns/1ps
`include "flash_guard_consts.vh"
module tb_flash_guard_host;
    localparam [21:0] BLK0 = 22'h00_0000;
    localparam [21:0] BLK1 = 22'h00_8000;
    localparam [21:0] BLK2 = 22'h01_0000;
    localparam [21:0] BLK3 = 22'h3F_8000;
    reg clock, reset, vpp_low, awvalid, wvalid, bready, arvalid, rready;
    reg [7:0] awaddr, araddr;
    reg [31:0] wdata, s;
    reg [1:0] r;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [21:0] flash_addr;
    wire [15:0] flash_dq_out, flash_dq_in;
    wire flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, write_protect_n_q;
    integer num_errors, samples_checked;

    flash_guard_host i_flash_guard_host (.clock, .reset, .awvalid, .awready, .awaddr, .awprot(3'h0),
        .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
        .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .flash_addr, .flash_dq_out, .flash_dq_oe,
        .flash_dq_in, .flash_ce_n, .flash_we_n, .flash_oe_n, .write_protect_n_q);
    flash_device_model i_flash_device_model (.reset, .vpp_low, .write_protect_n_q, .flash_addr,
        .flash_dq_out, .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_we_n, .flash_oe_n);

    task automatic report_and_stop;
        if (num_errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input [31:0] got, input [31:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Handshakes are sampled at the falling edge, which matches what the next rising edge takes.
    task automatic axi_wr(input [7:0] a, input [31:0] d, output [1:0] resp);
        reg aw_ok, w_ok, b_ok;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clock);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            resp = bresp;
            @(posedge clock);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end while (b_ok !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input [7:0] a, output [31:0] d, output [1:0] resp);
        reg ar_ok, r_ok;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clock);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            d = rdata;
            resp = rresp;
            @(posedge clock);
            if (ar_ok) arvalid <= 1'b0;
        end while (r_ok !== 1'b1);
        rready <= 1'b0;
    endtask

    task automatic op(input [3:0] c, input [21:0] a, input [15:0] d);
        reg [31:0] st;
        reg [1:0] rs;
        axi_wr(`REG_ADDR, {10'h000, a}, rs);
        axi_wr(`REG_WDATA, {16'h0000, d}, rs);
        axi_wr(`REG_CTRL, {28'h000_0000, c}, rs);
        st = 32'h0000_0001;
        while (st[0] !== 1'b0) axi_rd(`REG_STATUS, st, rs);
    endtask

    task automatic expect_rd(input [3:0] c, input [21:0] a, input [15:0] e);
        op(c, a, 16'h0000);
        axi_rd(`REG_RDATA, s, r);
        chk(s, {16'h0000, e});
    endtask

    task automatic expect_status(input [31:0] mask, input [31:0] e);
        axi_rd(`REG_STATUS, s, r);
        chk(s & mask, e);
    endtask

    task automatic hold_reset;
        @(posedge clock);
        reset <= 1'b1;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
    endtask

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        #1_500_000;
        num_errors = num_errors + 1;
        report_and_stop();
    end

    initial begin
        num_errors = 0;
        samples_checked = 0;
        {reset, vpp_low, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
        {awaddr, araddr, wdata} = 48'h0000_0000_0000;
        hold_reset();
        expect_status(32'h0000_073A, 32'h0000_0100);
        axi_rd(8'h40, s, r);
        chk({r, s[29:0]}, {2'b10, 30'h0});
        axi_wr(8'h44, 32'h0000_0001, r);
        chk({30'h0000_0000, r}, 32'h0000_0002);
        expect_rd(`OP_READ_LOCK, BLK0, 16'h0001);
        expect_rd(`OP_READ_LOCK, BLK3, 16'h0001);
        op(`OP_UNLOCK, BLK1, 16'h0000);
        expect_rd(`OP_READ_LOCK, BLK1, 16'h0000);
        expect_rd(`OP_READ_LOCK, BLK0, 16'h0001);
        op(`OP_LOCK, BLK1, 16'h0000);
        expect_rd(`OP_READ_LOCK, BLK1, 16'h0001);
        op(`OP_LOCKDOWN, BLK2, 16'h0000);
        expect_rd(`OP_READ_LOCK, BLK2, 16'h0003);
        op(`OP_UNLOCK, BLK2, 16'h0000);
        expect_rd(`OP_READ_LOCK, BLK2, 16'h0003);
        axi_wr(`REG_WP, 32'h0000_0001, r);
        expect_status(32'h0000_0400, 32'h0000_0400);
        op(`OP_UNLOCK, BLK2, 16'h0000);
        expect_rd(`OP_READ_LOCK, BLK2, 16'h0002);
        axi_wr(`REG_WP, 32'h0000_0000, r);
        expect_rd(`OP_READ_LOCK, BLK2, 16'h0003);
        hold_reset();
        expect_rd(`OP_READ_LOCK, BLK2, 16'h0001);
        op(`OP_SUSPEND, BLK3, 16'h0000);
        op(`OP_UNLOCK, BLK3, 16'h0000);
        expect_rd(`OP_READ_LOCK, BLK3, 16'h0000);
        op(`OP_RESUME, BLK3, 16'h0000);
        expect_rd(`OP_READ_ARRAY, 22'h00_1234, 16'h1234);
        op(`OP_OTP_PROG, 22'h00_0085, 16'h1234);
        expect_rd(`OP_READ_ID, 22'h00_0085, 16'h1234);
        op(`OP_OTP_LOCK, BLK0, 16'h0000);
        expect_rd(`OP_READ_ID, 22'h00_0080, 16'hFFFC);
        op(`OP_OTP_PROG, 22'h00_0085, 16'h0000);
        expect_status(32'h0000_0012, 32'h0000_0012);
        expect_rd(`OP_READ_ID, 22'h00_0085, 16'h1234);
        vpp_low <= 1'b1;
        op(`OP_OTP_PROG, 22'h00_0086, 16'h0000);
        expect_rd(`OP_READ_STATUS, BLK0, 16'h009A);
        expect_status(32'h0000_0008, 32'h0000_0008);
        expect_rd(`OP_READ_ID, 22'h00_0086, 16'hFFFF);
        report_and_stop();
    end
endmodule

bind flash_guard_host flash_guard_host_assertions i_flash_guard_host_assertions (.clock, .reset, .awvalid,
    .awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .flash_dq_out, .flash_dq_oe, .flash_ce_n,
    .flash_we_n, .flash_oe_n, .write_protect_n_q);
